// ==== rtl/reset_delay_sequencer_consts.vh ====
/*
  Constants of the reset and clock release sequencer: nominal delay times,
  the clock rate they are counted at, derived cycle counts and the encoding
  of the selected clock source.
  Assumes the sequencer counts on a free-running 125 MHz timebase.
*/
`ifndef RESET_DELAY_SEQUENCER_CONSTS_VH
`define RESET_DELAY_SEQUENCER_CONSTS_VH

// Timebase rate
`define RDS_CLK_MHZ        125

// Nominal delay times in their own units
`define RDS_T_POR_US       10
`define RDS_T_STARTUP_US   20
`define RDS_T_PWRT_MS      64
`define RDS_T_RST_US       20
`define RDS_T_LOCK_US      20
`define RDS_T_MON_US       100

// Cycle counts derived from times and rate
`define RDS_POR_CYC        (`RDS_T_POR_US * `RDS_CLK_MHZ)
`define RDS_STARTUP_CYC    (`RDS_T_STARTUP_US * `RDS_CLK_MHZ)
`define RDS_PWRT_CYC       (`RDS_T_PWRT_MS * 1000 * `RDS_CLK_MHZ)
`define RDS_RST_CYC        (`RDS_T_RST_US * `RDS_CLK_MHZ)
`define RDS_LOCK_CYC       (`RDS_T_LOCK_US * `RDS_CLK_MHZ)
`define RDS_MON_CYC        (`RDS_T_MON_US * `RDS_CLK_MHZ)

// Oscillator start-up counter
`define RDS_OST_W          10
`define RDS_OST_LAST       10'h3ff

// Clock source selection
`define RDS_SRC_CLK_IN         4'h0
`define RDS_SRC_FAST_RC        4'h1
`define RDS_SRC_SLOW_RC        4'h2
`define RDS_SRC_XTAL_MID       4'h3
`define RDS_SRC_XTAL_HIGH      4'h4
`define RDS_SRC_SEC_XTAL       4'h5
`define RDS_SRC_CLK_IN_PLL     4'h6
`define RDS_SRC_FAST_RC_PLL    4'h7
`define RDS_SRC_XTAL_MID_PLL   4'h8
`define RDS_SRC_XTAL_HIGH_PLL  4'h9

`endif

// ==== rtl/reset_delay_sequencer.v ====
/*
  Reset and clock release sequencer: times the internal system reset per
  reset type, alongside it the oscillator start-up and PLL lock delays, then the clock monitor delay,
  and arms the clock fail monitor with fast RC fallback.
  Assumes clk_sys is an always-running internal timebase, all inputs are
  synchronous to it and request inputs are one-cycle pulses.
*/
`timescale 1ns/1ns
`include "reset_delay_sequencer_consts.vh"

module reset_delay_sequencer #(
   parameter             CNT_W       = 23,
   parameter [CNT_W-1:0] PWRT_CYCLES = `RDS_PWRT_CYC,
   parameter [CNT_W-1:0] MON_CYCLES  = `RDS_MON_CYC
) (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       rst_n,
   // Reset sources, one-cycle pulses
   input  wire       power_on_req,
   input  wire       brownout_reset,
   input  wire       master_clear_pin,
   input  wire       other_reset_req,
   input  wire       wake_req,
   // Configuration
   input  wire       regulator_en,
   input  wire [3:0] clock_source,
   input  wire       clock_fail_monitor_en,
   input  wire       reselect_source_req,
   // Oscillator status
   input  wire       osc_period_tick,
   input  wire       clock_valid,
   // Sequencer outputs
   output wire       system_reset_internal,
   output wire       clock_released,
   output wire       cpu_run,
   output wire       clock_fail_monitor,
   output wire       fast_rc_fallback,
   output wire       clock_fail_trap
);

   localparam [1:0] R_POR   = 2'h0;
   localparam [1:0] R_START = 2'h1;
   localparam [1:0] R_RST   = 2'h2;
   localparam [1:0] R_DONE  = 2'h3;

   localparam [2:0] C_START = 3'h0;
   localparam [2:0] C_OST   = 3'h1;
   localparam [2:0] C_LOCK  = 3'h2;
   localparam [2:0] C_WAIT  = 3'h3;
   localparam [2:0] C_MDLY  = 3'h4;
   localparam [2:0] C_ARMED = 3'h5;

   // Cycle counts are integers; cut to the counter width on purpose
   localparam integer     POR_I       = `RDS_POR_CYC - 1;
   localparam integer     STARTUP_I   = `RDS_STARTUP_CYC - 1;
   localparam integer     RST_I       = `RDS_RST_CYC - 1;
   localparam integer     LOCK_I      = `RDS_LOCK_CYC - 1;
   localparam [CNT_W-1:0] POR_LEN     = POR_I[CNT_W-1:0];
   localparam [CNT_W-1:0] STARTUP_LEN = STARTUP_I[CNT_W-1:0];
   localparam [CNT_W-1:0] RST_LEN     = RST_I[CNT_W-1:0];
   localparam [CNT_W-1:0] LOCK_LEN    = LOCK_I[CNT_W-1:0];
   localparam [CNT_W-1:0] ONE         = {{(CNT_W-1){1'b0}}, 1'b1};

   reg [1:0]            rstate_ff;
   reg [1:0]            nxt_rstate;
   reg [CNT_W-1:0]      rcnt_ff;
   reg [CNT_W-1:0]      nxt_rcnt;
   reg                  wake_ff;
   reg                  nxt_wake;
   reg [2:0]            cstate_ff;
   reg [2:0]            nxt_cstate;
   reg [CNT_W-1:0]      ccnt_ff;
   reg [CNT_W-1:0]      nxt_ccnt;
   reg [`RDS_OST_W-1:0] ocnt_ff;
   reg [`RDS_OST_W-1:0] nxt_ocnt;
   reg                  mdly_ff;
   reg                  nxt_mdly;
   reg                  pll_ff;
   reg                  nxt_pll;
   reg                  system_reset_internal_ff;
   reg                  clk_rel_ff;
   reg                  cpu_run_ff;
   reg                  mon_ff;
   reg                  fallback_ff;
   reg                  nxt_fallback;
   reg                  trap_ff;
   reg                  nxt_trap;

   // Start-up stage length depends on the regulator
   function [CNT_W-1:0] startup_len;
      input reg_on;
      begin
         startup_len = reg_on ? STARTUP_LEN : PWRT_CYCLES - ONE;
      end
   endfunction

   function is_crystal;
      input [3:0] src;
      begin
         is_crystal = (src == `RDS_SRC_XTAL_MID) || (src == `RDS_SRC_XTAL_HIGH) ||
                      (src == `RDS_SRC_SEC_XTAL) || (src == `RDS_SRC_XTAL_MID_PLL) ||
                      (src == `RDS_SRC_XTAL_HIGH_PLL);
      end
   endfunction

   function uses_pll;
      input [3:0] src;
      begin
         uses_pll = (src == `RDS_SRC_CLK_IN_PLL) || (src == `RDS_SRC_FAST_RC_PLL) ||
                    (src == `RDS_SRC_XTAL_MID_PLL) || (src == `RDS_SRC_XTAL_HIGH_PLL);
      end
   endfunction

   // Reset delay chain; counts on clk_sys so its length ignores the source
   always @* begin
      nxt_rstate = rstate_ff;
      nxt_rcnt   = (rcnt_ff != {CNT_W{1'b0}}) ? rcnt_ff - ONE : rcnt_ff;
      nxt_wake   = wake_ff;
      if (power_on_req) begin
         nxt_rstate = R_POR;
         nxt_rcnt   = POR_LEN;
         nxt_wake   = 1'b0;
      end else if (brownout_reset) begin
         nxt_rstate = R_START;
         nxt_rcnt   = startup_len(regulator_en);
         nxt_wake   = 1'b0;
      end else if (master_clear_pin || other_reset_req) begin
         nxt_rstate = R_RST;
         nxt_rcnt   = RST_LEN;
         nxt_wake   = 1'b0;
      end else if (wake_req && rstate_ff == R_DONE && regulator_en) begin
         nxt_rstate = R_START;
         nxt_rcnt   = STARTUP_LEN;
         nxt_wake   = 1'b1;
      end else if (rcnt_ff == {CNT_W{1'b0}}) begin
         case (rstate_ff)
            R_POR: begin
               nxt_rstate = R_START;
               nxt_rcnt   = startup_len(regulator_en);
            end
            R_START: begin
               if (wake_ff) begin
                  nxt_rstate = R_DONE;
                  nxt_wake   = 1'b0;
               end else begin
                  nxt_rstate = R_RST;
                  nxt_rcnt   = RST_LEN;
               end
            end
            R_RST: nxt_rstate = R_DONE;
            default: nxt_rstate = R_DONE;
         endcase
      end
   end

   // Failure caught by the armed monitor in this cycle
   wire fail_seen = (cstate_ff == C_ARMED) && clock_fail_monitor_en && !clock_valid && !fallback_ff;

   // Clock release chain, started by power-on, brown-out or reselect; only its monitor delay waits for the reset chain
   always @* begin
      nxt_cstate   = cstate_ff;
      nxt_ccnt     = (ccnt_ff != {CNT_W{1'b0}}) ? ccnt_ff - ONE : ccnt_ff;
      nxt_ocnt     = ocnt_ff;
      nxt_mdly     = mdly_ff;
      nxt_pll      = pll_ff;
      nxt_fallback = fallback_ff;
      nxt_trap     = 1'b0;
      if (power_on_req || brownout_reset || reselect_source_req) begin
         nxt_cstate   = C_START;
         // A failure caught as software reselects wins over its clear
         nxt_fallback = fail_seen && !power_on_req && !brownout_reset;
         nxt_trap     = nxt_fallback;
      end else begin
         case (cstate_ff)
            C_START: begin
               nxt_mdly = is_crystal(clock_source) || uses_pll(clock_source);
               nxt_pll  = uses_pll(clock_source);
               nxt_ocnt = {`RDS_OST_W{1'b0}};
               nxt_ccnt = LOCK_LEN;
               if (is_crystal(clock_source))
                  nxt_cstate = C_OST;
               else if (uses_pll(clock_source))
                  nxt_cstate = C_LOCK;
               else
                  nxt_cstate = C_WAIT;
            end
            C_OST: begin
               if (osc_period_tick) begin
                  nxt_ocnt = ocnt_ff + 1'b1;
                  if (ocnt_ff == `RDS_OST_LAST)
                     nxt_cstate = pll_ff ? C_LOCK : C_WAIT;
               end
               nxt_ccnt = LOCK_LEN;
            end
            C_LOCK: begin
               if (ccnt_ff == {CNT_W{1'b0}})
                  nxt_cstate = C_WAIT;
            end
            C_WAIT: begin
               // Monitor timing starts only once the reset chain has let go
               if (rstate_ff == R_DONE && !wake_ff) begin
                  nxt_ccnt   = MON_CYCLES - ONE;
                  nxt_cstate = mdly_ff ? C_MDLY : C_ARMED;
               end
            end
            C_MDLY: begin
               if (ccnt_ff == {CNT_W{1'b0}})
                  nxt_cstate = C_ARMED;
            end
            C_ARMED: begin
               if (fail_seen) begin
                  nxt_fallback = 1'b1;
                  nxt_trap     = 1'b1;
               end
            end
            default: nxt_cstate = C_START;
         endcase
      end
   end

   // Fallback to fast RC counts as a released clock
   wire nxt_clk_rel = (nxt_cstate >= C_WAIT) || nxt_fallback;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstate_ff   <= R_POR;
         rcnt_ff     <= POR_LEN;
         wake_ff     <= 1'b0;
         cstate_ff   <= C_START;
         ccnt_ff     <= {CNT_W{1'b0}};
         ocnt_ff     <= {`RDS_OST_W{1'b0}};
         mdly_ff     <= 1'b0;
         pll_ff      <= 1'b0;
         system_reset_internal_ff   <= 1'b1;
         clk_rel_ff  <= 1'b0;
         cpu_run_ff  <= 1'b0;
         mon_ff      <= 1'b0;
         fallback_ff <= 1'b0;
         trap_ff     <= 1'b0;
      end else begin
         rstate_ff   <= nxt_rstate;
         rcnt_ff     <= nxt_rcnt;
         wake_ff     <= nxt_wake;
         cstate_ff   <= nxt_cstate;
         ccnt_ff     <= nxt_ccnt;
         ocnt_ff     <= nxt_ocnt;
         mdly_ff     <= nxt_mdly;
         pll_ff      <= nxt_pll;
         system_reset_internal_ff   <= (nxt_rstate != R_DONE) && !nxt_wake;
         clk_rel_ff  <= nxt_clk_rel;
         cpu_run_ff  <= (nxt_rstate == R_DONE) && nxt_clk_rel;
         mon_ff      <= (nxt_cstate == C_ARMED) && clock_fail_monitor_en;
         fallback_ff <= nxt_fallback;
         trap_ff     <= nxt_trap;
      end
   end

   assign system_reset_internal = system_reset_internal_ff;
   assign clock_released        = clk_rel_ff;
   assign cpu_run               = cpu_run_ff;
   assign clock_fail_monitor    = mon_ff;
   assign fast_rc_fallback      = fallback_ff;
   assign clock_fail_trap       = trap_ff;

endmodule

// ==== verif/reset_delay_sequencer_properties.sv ====
/*
  Port checker of the reset and clock release sequencer.
  Assumes one clock domain, bound to the top module from the testbench.
*/
`timescale 1ns/1ns
module reset_delay_sequencer_properties (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Requests and status
   input wire power_on_req,
   input wire master_clear_pin,
   input wire other_reset_req,
   input wire clock_fail_monitor_en,
   input wire clock_valid,
   // Outputs watched
   input wire system_reset_internal,
   input wire clock_released,
   input wire cpu_run,
   input wire clock_fail_monitor,
   input wire fast_rc_fallback,
   input wire clock_fail_trap
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Wraps past 65535 held cycles; fine for shortened power-up timer only
   reg [15:0] hold_ff;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) hold_ff <= 16'h0;
      else hold_ff <= system_reset_internal ? hold_ff + 16'h1 : 16'h0;
   end
   sequence fallback_entry;
      clock_fail_trap && fast_rc_fallback && clock_released;
   endsequence
   por_hold_a: assert property (power_on_req |=> system_reset_internal && !clock_released && !cpu_run)
      else $error("power-on did not hold reset and clock");
   pin_reset_a: assert property (master_clear_pin || other_reset_req |=> system_reset_internal)
      else $error("pin or other reset not taken");
   reset_min_a: assert property ($fell(system_reset_internal) |-> hold_ff >= 16'd2496)
      else $error("reset released too early");
   run_gate_a: assert property (cpu_run |-> clock_released && !system_reset_internal)
      else $error("run without clock or in reset");
   mon_start_a: assert property ($rose(clock_fail_monitor) |-> !system_reset_internal && clock_fail_monitor_en)
      else $error("monitor armed in reset or disabled");
   fallback_form_a: assert property ($rose(fast_rc_fallback) |-> fallback_entry)
      else $error("fallback without trap");
   trap_pulse_a: assert property (clock_fail_trap |=> !clock_fail_trap)
      else $error("trap longer than one cycle");
   trap_cause_a: assert property ($rose(clock_fail_trap) |-> $past(!clock_valid))
      else $error("trap with valid clock");
endmodule

// ==== verif/osc_model.sv ====
/*
  Oscillator status model at the far side of the sequencer.
  Assumes it is driven by the bench timebase; runs at half its rate.
*/
`timescale 1ns/1ns
module osc_model (
   // Timebase and controls
   input  wire clk_sys,
   input  wire osc_run,
   input  wire osc_good,
   // Oscillator status
   output reg  osc_period_tick,
   output reg  clock_valid
);
   reg phase_ff = 1'b0;
   initial begin
      osc_period_tick = 1'b0;
      clock_valid = 1'b0;
   end
   // Free-running, never tied to reset timing
   always @(negedge clk_sys) begin
      phase_ff <= ~phase_ff;
      osc_period_tick <= osc_run & phase_ff;
      clock_valid <= osc_run & osc_good;
   end
endmodule

// ==== verif/reset_delay_sequencer_tb.sv ====
/*
  Self-checking bench of the reset and clock release sequencer.
  Assumes shortened power-up timer and monitor delays via parameters.
*/
`timescale 1ns/1ns
module reset_delay_sequencer_tb;
   localparam PW = 40, MW = 30;
   reg clk_sys = 0, rst_n = 0, power_on_req = 0, brownout_reset = 0, master_clear_pin = 0;
   reg other_reset_req = 0, wake_req = 0, regulator_en = 1, clock_fail_monitor_en = 1;
   reg reselect_source_req = 0, osc_good = 1;
   reg [3:0] clock_source = 4'h9;
   wire osc_period_tick, clock_valid, system_reset_internal, clock_released, cpu_run;
   wire clock_fail_monitor, fast_rc_fallback, clock_fail_trap;
   integer n_mismatch = 0, comparisons = 0, seed = 32'hb6bee71a, n, i;
   always #4 clk_sys = ~clk_sys;
   osc_model i_osc (.clk_sys(clk_sys), .osc_run(rst_n), .osc_good(osc_good),
      .osc_period_tick(osc_period_tick), .clock_valid(clock_valid));
   reset_delay_sequencer #(.PWRT_CYCLES(PW), .MON_CYCLES(MW)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .power_on_req(power_on_req), .brownout_reset(brownout_reset), .master_clear_pin(master_clear_pin),
      .other_reset_req(other_reset_req), .wake_req(wake_req), .regulator_en(regulator_en),
      .clock_source(clock_source), .clock_fail_monitor_en(clock_fail_monitor_en),
      .reselect_source_req(reselect_source_req), .osc_period_tick(osc_period_tick),
      .clock_valid(clock_valid), .system_reset_internal(system_reset_internal),
      .clock_released(clock_released), .cpu_run(cpu_run), .clock_fail_monitor(clock_fail_monitor),
      .fast_rc_fallback(fast_rc_fallback), .clock_fail_trap(clock_fail_trap));
   // Expected reset hold per kind: 0 power-on, 1 brown-out, 2 pin, 3 other
   function integer exp_rst(input integer k);
      exp_rst = 2500 + (k < 2 ? (regulator_en ? 2500 : PW) : 0) + (k == 0 ? 1250 : 0);
   endfunction
   // Clock release after restart: 1024 model periods of 2 cycles for crystal sources, then 2500 lock cycles for PLL sources
   function integer exp_rel(input integer s);
      exp_rel = 1 + (((s >= 3 && s <= 5) || s >= 8) ? 1024 * 2 : 0) + (s >= 6 ? 2500 : 0);
   endfunction
   task check(input ok, input string msg);
      comparisons = comparisons + 1;
      if (ok !== 1'b1) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task pulse_rst(input integer k);
      @(negedge clk_sys);
      {power_on_req, brownout_reset, master_clear_pin, other_reset_req} = 4'h8 >> k;
      @(negedge clk_sys);
      {power_on_req, brownout_reset, master_clear_pin, other_reset_req} = 4'h0;
      for (n = 1; n < 90000 && system_reset_internal !== 1'b0; n = n + 1) @(negedge clk_sys);
      check(n >= exp_rst(k) - 3 && n <= exp_rst(k) + 3, "reset hold time");
   endtask
   task wait_run;
      for (n = 0; n < 9000 && cpu_run !== 1'b1; n = n + 1) @(negedge clk_sys);
      check(cpu_run === 1'b1 && clock_released === 1'b1, "no run");
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #(8 * 95000);
      n_mismatch = n_mismatch + 1;
      results;
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_n = 1;
      pulse_rst(0);
      wait_run;
      for (n = 0; n < MW + 8 && clock_fail_monitor !== 1'b1; n = n + 1) @(negedge clk_sys);
      check(n >= MW - 3 && clock_fail_monitor === 1'b1, "monitor delay");
      check(fast_rc_fallback === 1'b0, "false fallback");
      $display("test power-on done");
      for (i = 2; i < 4; i = i + 1) begin
         pulse_rst(i);
         check(clock_released === 1'b1, "clock restarted");
      end
      $display("test pin resets done");
      regulator_en = 0;
      clock_source = $unsigned($random(seed)) % 10;
      pulse_rst(1);
      wait_run;
      $display("test brown-out done");
      // One source of each class, restarted by reselect while the reset chain is idle
      for (i = 0; i < 4; i = i + 1) begin
         clock_source = i * 3;
         reselect_source_req = 1;
         @(negedge clk_sys);
         reselect_source_req = 0;
         for (n = 1; n < 6000 && clock_released !== 1'b1; n = n + 1) @(negedge clk_sys);
         check(n >= exp_rel(i * 3) - 3 && n <= exp_rel(i * 3) + 3, "clock release time");
         for (n = 0; n < MW + 8 && clock_fail_monitor !== 1'b1; n = n + 1) @(negedge clk_sys);
         check(n == ((i > 0) ? MW + 1 : 1), "monitor delay per source");
      end
      $display("test clock release done");
      for (i = 0; i < 10; i = i + 1) begin
         regulator_en = i[0];
         clock_source = i;
         osc_good = 0;
         pulse_rst(0);
         for (n = 0; n < 2000 && clock_fail_trap !== 1'b1; n = n + 1) @(negedge clk_sys);
         check(clock_fail_trap === 1'b1 && fast_rc_fallback === 1'b1 && clock_released === 1'b1,
            "no fallback");
         reselect_source_req = 1;
         osc_good = 1;
         @(negedge clk_sys);
         reselect_source_req = 0;
         @(negedge clk_sys);
         check(fast_rc_fallback === 1'b0, "fallback stuck");
      end
      $display("test fallback done");
      regulator_en = 1;
      pulse_rst(3);
      wait_run;
      wake_req = 1;
      @(negedge clk_sys);
      wake_req = 0;
      repeat (3) @(negedge clk_sys);
      check(cpu_run === 1'b0 && system_reset_internal === 1'b0, "wake gating");
      for (n = 4; n < 3000 && cpu_run !== 1'b1; n = n + 1) @(negedge clk_sys);
      check(n >= 2497 && n <= 2504, "wake start-up time");
      regulator_en = 0;
      wake_req = 1;
      @(negedge clk_sys);
      wake_req = 0;
      repeat (2) @(negedge clk_sys);
      check(cpu_run === 1'b1, "wake taken with regulator off");
      $display("test wake done");
      results;
   end
endmodule
bind reset_delay_sequencer reset_delay_sequencer_properties i_props (.clk_sys(clk_sys), .rst_n(rst_n),
   .power_on_req(power_on_req), .master_clear_pin(master_clear_pin), .other_reset_req(other_reset_req),
   .clock_fail_monitor_en(clock_fail_monitor_en), .clock_valid(clock_valid),
   .system_reset_internal(system_reset_internal), .clock_released(clock_released), .cpu_run(cpu_run),
   .clock_fail_monitor(clock_fail_monitor), .fast_rc_fallback(fast_rc_fallback),
   .clock_fail_trap(clock_fail_trap));
